// ---- rtl/ise_top.sv ----
`timescale 1ns/10ps
// How it works
// - Set error-to-PCI2 flag; W1C, reset clears.
// - Set error-to-processor-bus flag on PCI-1 error.
// - Set local DMA error flag on PCI-1.
// - Set address parity flag; W1C, reset clears.
// - Set retry-limit flag for PCI-2 cycles.
// - Set retry-limit flag for processor-bus cycles.
// - Set retry-limit flag for local DMA.
// - Keep PCI-1 control status error bits readable.
// - Enabled active status bits raise interrupt outputs.
// - Pin selection left to mapping and direction.
// - Top byte: host mask, processor, DMA enables.
// - Host mask is inverted: one masks.
// - Host mask shared with message unit field.
// - Second byte: PCI and external input enables.
// - PCI-1 hardware enable gates, resets to zero.
// - PCI-2 enable reserved in single-PCI variant.
// - Writing one to trigger sets doorbell status.
module ise_top
  import ise_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // Avalon-MM slave
  input wire logic [11:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // Access comes from the processor bus (mirrored bit order)
  input wire logic PB_ACCESS,
  // Variant strap
  input wire logic SINGLE_PCI_VARIANT,
  // PCI-1 error and retry-limit events, one-cycle pulses
  input wire logic PCI1_ERR_TO_PCI2,
  input wire logic PCI1_ERR_TO_PROCBUS,
  input wire logic PCI1_ERR_DMA_LOCAL,
  input wire logic PCI1_ADDR_PARITY_FLAG,
  input wire logic PCI1_RETRY_LIMIT_FROM_PCI2,
  input wire logic PCI1_RETRY_LIMIT_FROM_PROCBUS,
  input wire logic PCI1_RETRY_LIMIT_DMA_LOCAL,
  // Live PCI-1 control and status register
  input wire logic [31:0] PCI1_CONTROL_STATUS,
  // First interrupt status register and doorbell setting
  input wire logic [31:0] INTERRUPT_STATUS_0,
  output logic [7:0] DOORBELL_SET,
  // Outbound queue mask field shared with the message unit
  input wire logic OUTBOUND_QUEUE_MASK_WR,
  input wire logic OUTBOUND_QUEUE_MASK_WDATA,
  output logic OUTBOUND_QUEUE_MASK_FIELD,
  // Enabled interrupt requests, to the pin mapping logic
  output logic [31:0] IRQ_REQUEST_0,
  output logic [7:0] ERROR_STATUS_1
);

  logic ack_q;
  logic req;
  logic [31:0] wdata;
  logic [31:0] bmask;
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;
  logic [31:0] en0_q;
  logic [31:0] en0_rd;
  logic [31:0] en0_eff;
  logic [7:0] st1_q;
  logic [7:0] st1_set;
  logic [7:0] st1_clr;
  logic [7:0] db_q;
  logic wr_en0;
  logic wr_st1;
  logic [31:0] irq_q;

  function automatic logic [31:0] mirror32(input logic [31:0] v);
    logic [31:0] r;
    r = '0;
    for (int i = 0; i < 32; i++) begin
      r[i] = v[31 - i];
    end
    return r;
  endfunction

  // Every access waits exactly one cycle, so read data come from a flop.
  typedef enum logic [0:0] {
    ISE_BUS_IDLE = 1'b0,
    ISE_BUS_ANSWER = 1'b1
  } ise_bus_t;
  ise_bus_t bus_q;
  ise_bus_t bus_d;

  assign req = AVS_READ | AVS_WRITE;
  assign ack_q = (bus_q == ISE_BUS_ANSWER);
  assign AVS_WAITREQUEST = req & ~ack_q;

  // The answer state lasts one cycle, so the master must drop its request.
  always_comb begin
    bus_d = bus_q;
    case (bus_q)
      ISE_BUS_IDLE: begin
        if (req) begin
          bus_d = ISE_BUS_ANSWER;
        end
      end
      ISE_BUS_ANSWER: begin
        bus_d = ISE_BUS_IDLE;
      end
      default: begin
        bus_d = ISE_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      bus_q <= ISE_BUS_IDLE;
    end else begin
      bus_q <= bus_d;
    end
  end

  // The whole word is bit-reversed for the processor bus, so byte lanes
  // swap end for end and byte enables are mirrored along with the data.
  always_comb begin
    wdata = PB_ACCESS ? mirror32(AVS_WRITEDATA) : AVS_WRITEDATA;
    for (int b = 0; b < 4; b++) begin
      bmask[8*b +: 8] = {8{AVS_BYTEENABLE[PB_ACCESS ? 3 - b : b]}};
    end
  end

  assign wr_en0 = AVS_WRITE & ack_q & (AVS_ADDRESS == ISE_OFS_IRQ_EN0);
  assign wr_st1 = AVS_WRITE & ack_q & (AVS_ADDRESS == ISE_OFS_ERR_ST1);

  // One register per field; the message unit may also write the host mask.
  logic host_mask_q;
  logic proc_en_q;
  logic [3:0] dma_en_q;
  logic p2_hw_q;
  logic p1_hw_q;
  logic [5:0] ext_en_q;
  logic [7:0] mbox_en_q;

  // The message unit wins over a bus write to the mask in the same cycle.
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      host_mask_q <= ISE_EN0_RESET[ISE_EN0_HOST_MASK];
    end else if (OUTBOUND_QUEUE_MASK_WR) begin
      host_mask_q <= OUTBOUND_QUEUE_MASK_WDATA;
    end else if (wr_en0 & bmask[ISE_EN0_HOST_MASK]) begin
      host_mask_q <= wdata[ISE_EN0_HOST_MASK];
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      proc_en_q <= ISE_EN0_RESET[ISE_EN0_PROC_EN];
    end else if (wr_en0 & bmask[ISE_EN0_PROC_EN]) begin
      proc_en_q <= wdata[ISE_EN0_PROC_EN];
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      dma_en_q <= ISE_EN0_RESET[ISE_EN0_DMA_LO +: 4];
    end else if (wr_en0 & bmask[ISE_EN0_DMA_LO]) begin
      dma_en_q <= wdata[ISE_EN0_DMA_LO +: 4];
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      p2_hw_q <= ISE_EN0_RESET[ISE_EN0_P2_HW];
    end else if (wr_en0 & bmask[ISE_EN0_P2_HW]) begin
      p2_hw_q <= wdata[ISE_EN0_P2_HW];
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      p1_hw_q <= ISE_EN0_RESET[ISE_EN0_P1_HW];
    end else if (wr_en0 & bmask[ISE_EN0_P1_HW]) begin
      p1_hw_q <= wdata[ISE_EN0_P1_HW];
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      ext_en_q <= ISE_EN0_RESET[ISE_EN0_EXT_LO +: 6];
    end else if (wr_en0 & bmask[ISE_EN0_EXT_LO]) begin
      ext_en_q <= wdata[ISE_EN0_EXT_LO +: 6];
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      mbox_en_q <= ISE_EN0_RESET[ISE_EN0_MBOX_LO +: 8];
    end else if (wr_en0 & bmask[ISE_EN0_MBOX_LO]) begin
      mbox_en_q <= wdata[ISE_EN0_MBOX_LO +: 8];
    end
  end

  assign en0_q = {2'b00, host_mask_q, proc_en_q, dma_en_q, p2_hw_q,
                  p1_hw_q, ext_en_q, 8'h00, mbox_en_q};

  // The PCI-2 enable reads zero and has no effect in the single variant.
  always_comb begin
    en0_eff = en0_q;
    if (SINGLE_PCI_VARIANT) begin
      en0_eff = en0_q & ~ISE_EN0_SINGLE_RSVD;
    end
  end
  assign en0_rd = en0_eff;
  assign OUTBOUND_QUEUE_MASK_FIELD = en0_q[ISE_EN0_HOST_MASK];

  // Doorbell triggers are write-one-to-set pulses into the status register.
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      db_q <= 8'h00;
    end else if (wr_en0) begin
      db_q <= wdata[ISE_EN0_DB_LO +: 8] & bmask[ISE_EN0_DB_LO +: 8];
    end else begin
      db_q <= 8'h00;
    end
  end
  assign DOORBELL_SET = db_q;

  always_comb begin
    st1_set = '0;
    st1_set[ISE_ST1_ERR_PCI2] = PCI1_ERR_TO_PCI2;
    st1_set[ISE_ST1_ERR_PB] = PCI1_ERR_TO_PROCBUS;
    st1_set[ISE_ST1_ERR_DMA] = PCI1_ERR_DMA_LOCAL;
    st1_set[ISE_ST1_ADDR_PAR] = PCI1_ADDR_PARITY_FLAG;
    st1_set[ISE_ST1_RTY_PCI2] = PCI1_RETRY_LIMIT_FROM_PCI2;
    st1_set[ISE_ST1_RTY_PB] = PCI1_RETRY_LIMIT_FROM_PROCBUS;
    st1_set[ISE_ST1_RTY_DMA] = PCI1_RETRY_LIMIT_DMA_LOCAL;
    if (SINGLE_PCI_VARIANT) begin
      st1_set = st1_set & ~ISE_ST1_SINGLE_RSVD;
    end
    st1_clr = wr_st1 ? (wdata[7:0] & bmask[7:0]) : 8'h00;
  end

  // Each flag is its own cell, so a clear of one never disturbs the
  // others that are set in the same cycle.
  ise_w1c_flag #(
    .RESET_VAL(ISE_ST1_RESET[ISE_ST1_ERR_PCI2])
  ) err_pci2_i (
    .clk(CLK),
    .nrst(NRST),
    .set(st1_set[ISE_ST1_ERR_PCI2]),
    .clr(st1_clr[ISE_ST1_ERR_PCI2]),
    .flag_q(st1_q[ISE_ST1_ERR_PCI2])
  );

  ise_w1c_flag #(
    .RESET_VAL(ISE_ST1_RESET[ISE_ST1_ERR_PB])
  ) err_pb_i (
    .clk(CLK),
    .nrst(NRST),
    .set(st1_set[ISE_ST1_ERR_PB]),
    .clr(st1_clr[ISE_ST1_ERR_PB]),
    .flag_q(st1_q[ISE_ST1_ERR_PB])
  );

  ise_w1c_flag #(
    .RESET_VAL(ISE_ST1_RESET[ISE_ST1_ERR_DMA])
  ) err_dma_i (
    .clk(CLK),
    .nrst(NRST),
    .set(st1_set[ISE_ST1_ERR_DMA]),
    .clr(st1_clr[ISE_ST1_ERR_DMA]),
    .flag_q(st1_q[ISE_ST1_ERR_DMA])
  );

  ise_w1c_flag #(
    .RESET_VAL(ISE_ST1_RESET[ISE_ST1_ADDR_PAR])
  ) addr_par_i (
    .clk(CLK),
    .nrst(NRST),
    .set(st1_set[ISE_ST1_ADDR_PAR]),
    .clr(st1_clr[ISE_ST1_ADDR_PAR]),
    .flag_q(st1_q[ISE_ST1_ADDR_PAR])
  );

  ise_w1c_flag #(
    .RESET_VAL(ISE_ST1_RESET[ISE_ST1_RTY_PCI2])
  ) rty_pci2_i (
    .clk(CLK),
    .nrst(NRST),
    .set(st1_set[ISE_ST1_RTY_PCI2]),
    .clr(st1_clr[ISE_ST1_RTY_PCI2]),
    .flag_q(st1_q[ISE_ST1_RTY_PCI2])
  );

  ise_w1c_flag #(
    .RESET_VAL(ISE_ST1_RESET[ISE_ST1_RTY_PB])
  ) rty_pb_i (
    .clk(CLK),
    .nrst(NRST),
    .set(st1_set[ISE_ST1_RTY_PB]),
    .clr(st1_clr[ISE_ST1_RTY_PB]),
    .flag_q(st1_q[ISE_ST1_RTY_PB])
  );

  ise_w1c_flag #(
    .RESET_VAL(ISE_ST1_RESET[ISE_ST1_RTY_DMA])
  ) rty_dma_i (
    .clk(CLK),
    .nrst(NRST),
    .set(st1_set[ISE_ST1_RTY_DMA]),
    .clr(st1_clr[ISE_ST1_RTY_DMA]),
    .flag_q(st1_q[ISE_ST1_RTY_DMA])
  );

  // Bit 0 of the flag byte has no event behind it and always reads zero.
  assign st1_q[0] = 1'b0;
  assign ERROR_STATUS_1 = st1_q;

  // Requests carry no pin choice; mapping logic outside picks the pin.
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      irq_q <= 32'h0000_0000;
    end else begin
      irq_q <= INTERRUPT_STATUS_0 & en0_eff;
      irq_q[ISE_EN0_HOST_MASK] <= INTERRUPT_STATUS_0[ISE_EN0_HOST_MASK]
                                & ~en0_q[ISE_EN0_HOST_MASK];
      irq_q[ISE_EN0_DB_LO +: 8] <= INTERRUPT_STATUS_0[ISE_EN0_DB_LO +: 8];
    end
  end
  assign IRQ_REQUEST_0 = irq_q;

  always_comb begin
    rdata_d = ISE_RD_UNMAPPED;
    if (AVS_ADDRESS == ISE_OFS_IRQ_EN0) begin
      rdata_d = en0_rd;
    end else if (AVS_ADDRESS == ISE_OFS_ERR_ST1) begin
      rdata_d = {24'h000000, st1_q};
    end else if (AVS_ADDRESS == ISE_OFS_PCI1_CONTROL_STATUS) begin
      rdata_d = PCI1_CONTROL_STATUS;
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      rdata_q <= 32'h0000_0000;
    end else if (AVS_READ & ~ack_q) begin
      rdata_q <= PB_ACCESS ? mirror32(rdata_d) : rdata_d;
    end
  end
  assign AVS_READDATA = rdata_q;

endmodule

module ise_w1c_flag
  import ise_pkg::*;
#(
  parameter logic RESET_VAL = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Hardware event and software clear
  input wire logic set,
  input wire logic clr,
  // Stored flag
  output logic flag_q
);

  // A new event in the clearing cycle keeps the flag set.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      flag_q <= RESET_VAL;
    end else if (set) begin
      flag_q <= 1'b1;
    end else if (clr) begin
      flag_q <= 1'b0;
    end
  end

endmodule

// ---- rtl/ise_pkg.sv ----
package ise_pkg;

  // Byte addresses on the register bus.
  localparam logic [11:0] ISE_OFS_IRQ_EN0 = 12'h418;
  localparam logic [11:0] ISE_OFS_ERR_ST1 = 12'h414;
  localparam logic [11:0] ISE_OFS_PCI1_CONTROL_STATUS = 12'h004;

  // Field positions in interrupt_enable_0.
  localparam int ISE_EN0_HOST_MASK = 29;
  localparam int ISE_EN0_PROC_EN = 28;
  localparam int ISE_EN0_DMA_LO = 24;
  localparam int ISE_EN0_P2_HW = 23;
  localparam int ISE_EN0_P1_HW = 22;
  localparam int ISE_EN0_EXT_LO = 16;
  localparam int ISE_EN0_DB_LO = 8;
  localparam int ISE_EN0_MBOX_LO = 0;

  // Bits of interrupt_enable_0 that hold storage (all but the doorbell
  // triggers and the reserved top two bits).
  localparam logic [31:0] ISE_EN0_RW_MASK = 32'h3fff_00ff;
  localparam logic [31:0] ISE_EN0_RESET = 32'h0000_0000;

  // Field positions in error_interrupt_status_1 (PCI-1 byte).
  localparam int ISE_ST1_ERR_PCI2 = 7;
  localparam int ISE_ST1_ERR_PB = 6;
  localparam int ISE_ST1_ERR_DMA = 5;
  localparam int ISE_ST1_ADDR_PAR = 4;
  localparam int ISE_ST1_RTY_PCI2 = 3;
  localparam int ISE_ST1_RTY_PB = 2;
  localparam int ISE_ST1_RTY_DMA = 1;
  localparam logic [7:0] ISE_ST1_RESET = 8'h00;

  // Bits reserved when only one PCI interface is fitted.
  localparam logic [7:0] ISE_ST1_SINGLE_RSVD = 8'h88;
  localparam logic [31:0] ISE_EN0_SINGLE_RSVD = 32'h0080_0000;

  localparam logic [31:0] ISE_RD_UNMAPPED = 32'h0000_0000;

endpackage

// ---- sim/ise_host.sv ----
`timescale 1ns/10ps
module ise_host (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Doorbell pulses and the bench's own set and clear vectors
  input wire logic [7:0] db_set,
  input wire logic [31:0] src,
  input wire logic [31:0] clr,
  output logic [31:0] status_q
);
  // Status holds until software clears it; a trigger alone never clears.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      status_q <= 32'h0000_0000;
    end else begin
      status_q <= (status_q & ~clr) | src | {16'h0000, db_set, 8'h00};
    end
  end
endmodule

// ---- sim/ise_chk.sv ----
`timescale 1ns/10ps
module ise_chk
  import ise_pkg::*;
(
  // Watched ports
  input wire logic CLK,
  input wire logic NRST,
  input wire logic [11:0] AVS_ADDRESS,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  input wire logic AVS_WAITREQUEST,
  input wire logic PB_ACCESS,
  input wire logic SINGLE_PCI_VARIANT,
  input wire logic PCI1_ERR_TO_PCI2,
  input wire logic PCI1_ERR_TO_PROCBUS,
  input wire logic PCI1_ADDR_PARITY_FLAG,
  input wire logic PCI1_RETRY_LIMIT_FROM_PROCBUS,
  input wire logic [31:0] INTERRUPT_STATUS_0,
  input wire logic [7:0] DOORBELL_SET,
  input wire logic OUTBOUND_QUEUE_MASK_WR,
  input wire logic OUTBOUND_QUEUE_MASK_WDATA,
  input wire logic OUTBOUND_QUEUE_MASK_FIELD,
  input wire logic [31:0] IRQ_REQUEST_0,
  input wire logic [7:0] ERROR_STATUS_1
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  sequence en0_wr;
    AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == ISE_OFS_IRQ_EN0;
  endsequence
  AST_ERR_PCI2: assert property (
    PCI1_ERR_TO_PCI2 && !SINGLE_PCI_VARIANT |=> ERROR_STATUS_1[7])
    else $error("bit 7");
  AST_ERR_PB: assert property (
    PCI1_ERR_TO_PROCBUS |=> ERROR_STATUS_1[6]) else $error("bit 6");
  AST_PAR: assert property (
    PCI1_ADDR_PARITY_FLAG |=> ERROR_STATUS_1[4]) else $error("bit 4");
  AST_RTY_PB: assert property (
    PCI1_RETRY_LIMIT_FROM_PROCBUS |=> ERROR_STATUS_1[2]) else $error("bit 2");
  AST_IRQ: assert property ($past(NRST) |->
    IRQ_REQUEST_0[31:30] == 2'h0 &&
    IRQ_REQUEST_0[15:8] == $past(INTERRUPT_STATUS_0[15:8]))
    else $error("irq");
  AST_HOST: assert property (IRQ_REQUEST_0[29] |->
    $past(INTERRUPT_STATUS_0[29]) &&
    !$past(OUTBOUND_QUEUE_MASK_FIELD)) else $error("mask");
  AST_DB: assert property (en0_wr ##0 (AVS_BYTEENABLE[1] && !PB_ACCESS) |=>
    DOORBELL_SET == $past(AVS_WRITEDATA[15:8])) else $error("doorbell");
  AST_ALIAS: assert property (OUTBOUND_QUEUE_MASK_WR |=>
    OUTBOUND_QUEUE_MASK_FIELD == $past(OUTBOUND_QUEUE_MASK_WDATA))
    else $error("alias");
endmodule

// ---- sim/tb.sv ----
`timescale 1ns/10ps
module tb
  import ise_pkg::*;
;
  logic CLK = 1'b0, NRST = 1'b0, AVS_READ = 1'b0, AVS_WRITE = 1'b0;
  logic PB_ACCESS = 1'b0, SINGLE_PCI_VARIANT = 1'b0, AVS_WAITREQUEST;
  logic OUTBOUND_QUEUE_MASK_WR = 1'b0, OUTBOUND_QUEUE_MASK_WDATA = 1'b0;
  logic OUTBOUND_QUEUE_MASK_FIELD;
  logic [11:0] AVS_ADDRESS = 12'h000;
  logic [3:0] AVS_BYTEENABLE = 4'hf;
  logic [6:0] ev = 7'h00;
  logic [7:0] DOORBELL_SET, ERROR_STATUS_1;
  logic [31:0] AVS_WRITEDATA = 32'h0, PCI1_CONTROL_STATUS = 32'hc000_0300;
  logic [31:0] src = 32'h0, clr = 32'h0, st, q, AVS_READDATA, IRQ_REQUEST_0;
  int err_count = 0, samples_checked = 0;
  always #12.5 CLK = ~CLK;
  ise_top ise_top_i (.PCI1_ERR_TO_PCI2(ev[6]), .PCI1_ERR_TO_PROCBUS(ev[5]),
    .PCI1_ERR_DMA_LOCAL(ev[4]), .PCI1_ADDR_PARITY_FLAG(ev[3]),
    .PCI1_RETRY_LIMIT_FROM_PCI2(ev[2]), .PCI1_RETRY_LIMIT_FROM_PROCBUS(ev[1]),
    .PCI1_RETRY_LIMIT_DMA_LOCAL(ev[0]), .INTERRUPT_STATUS_0(st), .*);
  ise_host ise_host_i (.clk(CLK), .nrst(NRST), .db_set(DOORBELL_SET),
    .src(src), .clr(clr), .status_q(st));
  task stop_test;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %h not %h", $time, got, exp);
    end
  endtask
  task tick(input int k);
    repeat (k) @(posedge CLK);
  endtask
  // The wait is judged at each rising edge, where the write lands.
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge CLK);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_WRITE <= w;
    AVS_READ <= !w;
    do @(posedge CLK); while (AVS_WAITREQUEST !== 1'b0 && ++n < 50);
    if (n >= 50) begin
      err_count++;
      $display("wrong value at %0t: bus timeout", $time);
      stop_test;
    end
    q = AVS_READDATA;
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task pulse;
    ev <= 7'h7f;
    tick(1);
    ev <= 7'h00;
  endtask
  initial begin
    tick(10);
    NRST <= 1'b1;
    rd(ISE_OFS_IRQ_EN0, 32'h0);
    rd(ISE_OFS_ERR_ST1, 32'h0);
    rd(12'h7fc, 32'h0);
    $display("test reset done");
    src <= 32'hffff_00ff;
    bus(1'b1, ISE_OFS_IRQ_EN0, 32'hffff_ffff);
    rd(ISE_OFS_IRQ_EN0, ISE_EN0_RW_MASK);
    chk(IRQ_REQUEST_0, 32'h1fff_ffff);
    bus(1'b1, ISE_OFS_IRQ_EN0, 32'h0);
    tick(2);
    chk(IRQ_REQUEST_0, 32'h2000_ff00);
    src <= 32'h0;
    clr <= 32'hffff_ffff;
    tick(3);
    chk(IRQ_REQUEST_0, 32'h0);
    OUTBOUND_QUEUE_MASK_WR <= 1'b1;
    OUTBOUND_QUEUE_MASK_WDATA <= 1'b1;
    tick(1);
    OUTBOUND_QUEUE_MASK_WR <= 1'b0;
    rd(ISE_OFS_IRQ_EN0, 32'h2000_0000);
    chk({31'h0, OUTBOUND_QUEUE_MASK_FIELD}, 32'h1);
    PB_ACCESS <= 1'b1;
    bus(1'b1, ISE_OFS_IRQ_EN0, 32'h8000_0000);
    PB_ACCESS <= 1'b0;
    rd(ISE_OFS_IRQ_EN0, 32'h0000_0001);
    rd(ISE_OFS_PCI1_CONTROL_STATUS, 32'hc000_0300);
    $display("test enable done");
    pulse;
    rd(ISE_OFS_ERR_ST1, 32'h0000_00fe);
    bus(1'b1, ISE_OFS_ERR_ST1, 32'h0000_0090);
    rd(ISE_OFS_ERR_ST1, 32'h0000_006e);
    chk({24'h0, ERROR_STATUS_1}, 32'h0000_006e);
    SINGLE_PCI_VARIANT <= 1'b1;
    bus(1'b1, ISE_OFS_ERR_ST1, 32'h0000_00ff);
    pulse;
    rd(ISE_OFS_ERR_ST1, 32'h0000_0076);
    bus(1'b1, ISE_OFS_IRQ_EN0, 32'hffff_ffff);
    rd(ISE_OFS_IRQ_EN0, 32'h3f7f_00ff);
    $display("test status done");
    NRST <= 1'b0;
    tick(2);
    NRST <= 1'b1;
    rd(ISE_OFS_IRQ_EN0, 32'h0);
    $display("test second reset done");
    stop_test;
  end
  initial begin
    #100000;
    err_count++;
    stop_test;
  end
endmodule
bind ise_top ise_chk ise_chk_i (.*);
